/* src/conpdo_map.svh */
// Constant map of the process-data slave: identifiers, command codes,
// default offsets, reset values and timing counts.
// Assumes a 25 MHz ref_clk; included by every design file that needs it.
`ifndef CONPDO_MAP_SVH
`define CONPDO_MAP_SVH

`define CONPDO_NMT_ID        11'h000
`define CONPDO_SYNC_ID       11'h080
`define CONPDO_CS_START      8'h01
`define CONPDO_CS_PREOP      8'h80
`define CONPDO_NODE_ALL      8'h00
`define CONPDO_NMT_MIN_DLC   4'h2

`define CONPDO_TX_BASE0      11'h180
`define CONPDO_TX_BASE1      11'h280
`define CONPDO_TX_BASE2      11'h380
`define CONPDO_TX_BASE3      11'h480
`define CONPDO_RX_BASE0      11'h200
`define CONPDO_RX_BASE1      11'h300
`define CONPDO_RX_BASE2      11'h400
`define CONPDO_RX_BASE3      11'h500
`define CONPDO_COB_MIN       11'h181
`define CONPDO_COB_MAX       11'h57f

`define CONPDO_TYPE_SYNC1    8'h01
`define CONPDO_TYPE_RTR      8'hfd
`define CONPDO_TYPE_EVENT    8'hff
`define CONPDO_MAX_BYTES     4'h8

`define CONPDO_RST_TYPE      8'hff
`define CONPDO_RST_INHIBIT   16'h0000
`define CONPDO_RST_MAP_CNT   3'h0
`define CONPDO_RST_MAP_LEN   8'h00

`define CONPDO_CLK_MHZ       25
`define CONPDO_INH_UNIT_NS   100000
`define CONPDO_INH_UNIT_CYC  ((`CONPDO_INH_UNIT_NS * `CONPDO_CLK_MHZ + 999) / 1000)

`endif

/* src/conpdo_pkg.sv */
// Types shared by the process-data slave.
// Assumes nothing beyond a SystemVerilog compiler.
package conpdo_pkg;

  typedef enum logic [1:0] {
    nmt_init,
    nmt_preop,
    nmt_oper
  } conpdo_nmt_t;

endpackage : conpdo_pkg

/* src/conpdo_buf.sv */
// Two-entry buffer in the transmit path.
// Assumes the consumer may stall; flush empties it in one cycle.
`timescale 1ns/1ps
`default_nettype none

module conpdo_buf #(
  parameter int W = 79
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  logic [W-1:0] e0_reg;
  logic [W-1:0] e1_reg;
  logic [1:0]   cnt_reg;
  wire          wr = in_valid & in_ready;
  wire          rd = out_valid & out_ready;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = e0_reg;

  always_ff @(posedge ref_clk) begin
    if (!nrst || flush) begin
      cnt_reg <= 2'h0;
      e0_reg  <= '0;
      e1_reg  <= '0;
    end else begin
      unique case ({wr, rd})
        2'b10: begin
          if (cnt_reg == 2'h0) e0_reg <= in_data;
          else e1_reg <= in_data;
          cnt_reg <= cnt_reg + 2'h1;
        end
        2'b01: begin
          e0_reg  <= e1_reg;
          cnt_reg <= cnt_reg - 2'h1;
        end
        2'b11: begin
          if (cnt_reg == 2'h1) begin
            e0_reg <= in_data;
          end else begin
            e0_reg <= e1_reg;
            e1_reg <= in_data;
          end
        end
        2'b00: ;
      endcase
    end
  end

endmodule : conpdo_buf

`default_nettype wire

/* src/conpdo_inhibit.sv */
// Inhibit timer of one transmit object, counted in 100 us units.
// Assumes start pulses once per transmission.
`timescale 1ns/1ps
`default_nettype none
`include "conpdo_map.svh"

module conpdo_inhibit #(
  parameter int UNIT_CYC = `CONPDO_INH_UNIT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [15:0] inh_time,
  output logic             ready
);

  localparam int PW = $clog2(UNIT_CYC + 1);

  logic [PW-1:0] pre_reg;
  logic [15:0]   units_reg;
  wire           wrap = (pre_reg == PW'(UNIT_CYC - 1));

  generate
    if (UNIT_CYC < 1) begin : g_chk
      $error("conpdo_inhibit: UNIT_CYC must be at least 1");
    end
  endgenerate

  assign ready = (units_reg == 16'h0000);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pre_reg   <= '0;
      units_reg <= 16'h0000;
    end else if (start) begin
      pre_reg   <= '0;
      units_reg <= inh_time; // R9
    end else if (!ready) begin
      pre_reg <= wrap ? '0 : pre_reg + PW'(1);
      if (wrap) units_reg <= units_reg - 16'h0001;
    end
  end

endmodule : conpdo_inhibit

`default_nettype wire

/* src/conpdo_slave.sv */
// Network-management state machine and process-data engine of a CAN node.
// Assumes a CAN controller on ref_clk that hands over received frames as
// one-cycle strobes and accepts transmit frames by valid/ready.
// Functional notes
// R1: A process-data frame carries at most eight bytes, filled by the mapping.
// R2: Each identifier has one producer; any number of nodes may consume it.
// R3: After reset and initialisation the node enters Pre-Operational by itself.
// R4: Pre-Operational allows configuration but no process-data send or receive.
// R5: Identifier 0, command 0x01, node 0 or own: enter Operational.
// R6: Identifier 0, command 0x80, node 0 or own: back to Pre-Operational.
// R7: A remote request on an asynchronous object's identifier makes it transmit.
// R8: A change of a mapped value triggers an event-driven transmit object.
// R9: Inhibit time in 100 us units sets the least spacing between transmissions.
// R10: Cyclic synchronous objects wait for Sync, then send their sampled values.
// R11: Only one transmission per Sync is supported; other rates are refused.
// R12: Frames go out unconfirmed, carrying only identifier and payload.
// R13: Mapping sets which values are packed, in what order and length.
// R14: Mapping may change in Pre-Operational; Operational changes are refused here.
// R15: The configuring party moves the node to Pre-Operational before configuring.
// R16: Identifier defaults to base offset plus node id, or a value in range.
// R17: Commands for other nodes, or with unknown codes, are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "conpdo_map.svh"

module conpdo_slave #(
  parameter int N_TPDO   = 4,
  parameter int N_RPDO   = 4,
  parameter int UNIT_CYC = `CONPDO_INH_UNIT_CYC
) (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic [6:0]            node_id,
  input  wire logic                  init_done,
  input  wire logic                  rx_valid,
  input  wire logic [10:0]           rx_id,
  input  wire logic                  rx_rtr,
  input  wire logic [3:0]            rx_dlc,
  input  wire logic [63:0]           rx_data,
  input  wire logic                  cfg_wr,
  input  wire logic                  cfg_rx,
  input  wire logic [1:0]            cfg_sel,
  input  wire logic                  cfg_custom,
  input  wire logic [10:0]           cfg_cob,
  input  wire logic [7:0]            cfg_type,
  input  wire logic [15:0]           cfg_inhibit,
  input  wire logic [2:0]            cfg_map_cnt,
  input  wire logic [7:0]            cfg_map_len,
  output logic                       cfg_ack,
  output logic                       cfg_err,
  input  wire logic [N_TPDO*128-1:0] app_val,
  output logic                       tx_valid,
  input  wire logic                  tx_ready,
  output logic      [10:0]           tx_id,
  output logic      [3:0]            tx_dlc,
  output logic      [63:0]           tx_data,
  output logic                       rpdo_valid,
  output logic      [1:0]            rpdo_sel,
  output logic      [3:0]            rpdo_dlc,
  output logic      [63:0]           rpdo_data,
  output logic      [1:0]            nmt_state,
  output logic                       operational
);

  generate
    if (N_TPDO < 2 || N_TPDO > 4 || N_RPDO < 1 || N_RPDO > 4) begin : g_chk
      $error("conpdo_slave: N_TPDO must be 2..4 and N_RPDO 1..4");
    end
  endgenerate

  // Default identifier per object, before the node id is added
  function automatic logic [10:0] pdo_base(input logic rx, input logic [1:0] k);
    logic [10:0] b;
    b = 11'h000;
    unique case (k)
      2'h0: b = rx ? `CONPDO_RX_BASE0 : `CONPDO_TX_BASE0;
      2'h1: b = rx ? `CONPDO_RX_BASE1 : `CONPDO_TX_BASE1;
      2'h2: b = rx ? `CONPDO_RX_BASE2 : `CONPDO_TX_BASE2;
      2'h3: b = rx ? `CONPDO_RX_BASE3 : `CONPDO_TX_BASE3;
    endcase
    return b;
  endfunction : pdo_base

  // Packs up to four 32-bit values; length code n means n+1 bytes.
  // Result is {dlc, data}; bytes past the eighth are dropped.
  function automatic logic [67:0] pack(input logic [127:0] v, input logic [2:0] cnt,
                                       input logic [7:0] lens);
    logic [63:0] d;
    logic [3:0]  pos;
    d   = 64'h0;
    pos = 4'h0;
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 4; b++) begin
        if (3'(i) < cnt && 2'(b) <= lens[2*i +: 2] && pos < `CONPDO_MAX_BYTES) begin // R1 R13
          d[8*pos +: 8] = v[32*i + 8*b +: 8];
          pos           = pos + 4'h1;
        end
      end
    end
    return {pos, d};
  endfunction : pack

  function automatic logic [1:0] first_set(input logic [3:0] v);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) r = 2'(i);
    end
    return r;
  endfunction : first_set

  // Network management
  conpdo_pkg::conpdo_nmt_t state_reg;
  conpdo_pkg::conpdo_nmt_t state_next;

  wire [7:0] rx_cs    = rx_data[7:0];
  wire [7:0] rx_node  = rx_data[15:8];
  wire       nmt_hit  = rx_valid & ~rx_rtr & (rx_id == `CONPDO_NMT_ID) & (rx_dlc >= `CONPDO_NMT_MIN_DLC) &
                        ((rx_node == `CONPDO_NODE_ALL) | (rx_node == {1'b0, node_id})); // R17
  wire       sync_hit = rx_valid & ~rx_rtr & (rx_id == `CONPDO_SYNC_ID);
  wire       oper     = (state_reg == conpdo_pkg::nmt_oper);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      conpdo_pkg::nmt_init:  if (init_done) state_next = conpdo_pkg::nmt_preop; // R3
      conpdo_pkg::nmt_preop: if (nmt_hit && rx_cs == `CONPDO_CS_START) state_next = conpdo_pkg::nmt_oper; // R5
      conpdo_pkg::nmt_oper:  if (nmt_hit && rx_cs == `CONPDO_CS_PREOP) state_next = conpdo_pkg::nmt_preop; // R6
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) state_reg <= conpdo_pkg::nmt_init;
    else state_reg <= state_next;
  end

  assign nmt_state   = state_reg;
  assign operational = oper;

  // Object configuration
  logic [10:0] tcob_reg   [N_TPDO];
  logic        tcust_reg  [N_TPDO];
  logic [7:0]  ttype_reg  [N_TPDO];
  logic [15:0] tinh_reg   [N_TPDO];
  logic [2:0]  tmapc_reg  [N_TPDO];
  logic [7:0]  tmapl_reg  [N_TPDO];
  logic [10:0] rcob_reg   [N_RPDO];
  logic        rcust_reg  [N_RPDO];
  logic        cfg_ack_reg;
  logic        cfg_err_reg;

  wire cob_ok   = ~cfg_custom | ((cfg_cob >= `CONPDO_COB_MIN) & (cfg_cob <= `CONPDO_COB_MAX)); // R16
  wire type_ok  = cfg_rx | (cfg_type == `CONPDO_TYPE_SYNC1) | (cfg_type == `CONPDO_TYPE_RTR) |
                  (cfg_type == `CONPDO_TYPE_EVENT); // R11
  wire map_ok   = cfg_map_cnt <= 3'h4;
  wire sel_ok   = cfg_rx ? (32'(cfg_sel) < N_RPDO) : (32'(cfg_sel) < N_TPDO);
  // Operational writes refused: no consistency guard exists for live mapping
  wire cfg_good = (state_reg == conpdo_pkg::nmt_preop) & cob_ok & type_ok & map_ok & sel_ok; // R4 R14 R15
  wire cfg_take = cfg_wr & cfg_good;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int k = 0; k < N_TPDO; k++) begin
        tcob_reg[k]  <= 11'h000;
        tcust_reg[k] <= 1'b0;
        ttype_reg[k] <= `CONPDO_RST_TYPE;
        tinh_reg[k]  <= `CONPDO_RST_INHIBIT;
        tmapc_reg[k] <= `CONPDO_RST_MAP_CNT;
        tmapl_reg[k] <= `CONPDO_RST_MAP_LEN;
      end
      for (int k = 0; k < N_RPDO; k++) begin
        rcob_reg[k]  <= 11'h000;
        rcust_reg[k] <= 1'b0;
      end
    end else if (cfg_take && cfg_rx) begin
      rcob_reg[cfg_sel]  <= cfg_cob;
      rcust_reg[cfg_sel] <= cfg_custom;
    end else if (cfg_take) begin
      tcob_reg[cfg_sel]  <= cfg_cob;
      tcust_reg[cfg_sel] <= cfg_custom;
      ttype_reg[cfg_sel] <= cfg_type;
      tinh_reg[cfg_sel]  <= cfg_inhibit;
      tmapc_reg[cfg_sel] <= cfg_map_cnt; // R13
      tmapl_reg[cfg_sel] <= cfg_map_len;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cfg_ack_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
    end else begin
      cfg_ack_reg <= cfg_take;
      cfg_err_reg <= cfg_wr & ~cfg_good;
    end
  end

  assign cfg_ack = cfg_ack_reg;
  assign cfg_err = cfg_err_reg;

  // Transmit objects
  logic [10:0]       tcob    [N_TPDO];
  logic [67:0]       tpk     [N_TPDO];
  logic [63:0]       last_reg[N_TPDO];
  logic [3:0]        cand;
  logic [N_TPDO-1:0] trig;
  logic [N_TPDO-1:0] inh_rdy;
  logic [N_TPDO-1:0] issue;
  logic [N_TPDO-1:0] pend_reg;
  logic [N_TPDO-1:0] last_ok_reg;
  logic [1:0]        sel;
  logic              buf_in_ready;
  logic              go;

  for (genvar k = 0; k < N_TPDO; k++) begin : g_tpdo
    wire async_t = (ttype_reg[k] == `CONPDO_TYPE_RTR) | (ttype_reg[k] == `CONPDO_TYPE_EVENT);
    wire t_rtr   = rx_valid & rx_rtr & (rx_id == tcob[k]) & async_t; // R7
    wire t_sync  = sync_hit & (ttype_reg[k] == `CONPDO_TYPE_SYNC1); // R10 R11
    wire t_ev    = (ttype_reg[k] == `CONPDO_TYPE_EVENT) &
                   (~last_ok_reg[k] | (tpk[k][63:0] != last_reg[k])) & ~issue[k]; // R8

    assign tcob[k] = tcust_reg[k] ? tcob_reg[k] : pdo_base(1'b0, 2'(k)) + {4'h0, node_id}; // R16
    assign tpk[k]  = pack(app_val[128*k +: 128], tmapc_reg[k], tmapl_reg[k]);
    // Empty mapping disables the object
    assign trig[k]  = oper & (tmapc_reg[k] != 3'h0) & (t_rtr | t_sync | t_ev); // R4
    assign issue[k] = go & (sel == 2'(k));

    conpdo_inhibit #(
      .UNIT_CYC (UNIT_CYC)
    ) u_inh (
      .ref_clk  (ref_clk),
      .nrst     (nrst),
      .start    (issue[k]),
      .inh_time (tinh_reg[k]),
      .ready    (inh_rdy[k])
    );
  end

  assign cand = 4'(pend_reg & inh_rdy); // R9
  assign sel  = first_set(cand);
  assign go   = oper & buf_in_ready & (cand != 4'h0);

  // Set wins over the clear of the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst || !oper) begin
      pend_reg    <= '0; // R4
      last_ok_reg <= '0;
    end else begin
      pend_reg    <= trig | (pend_reg & ~issue);
      last_ok_reg <= last_ok_reg | issue;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      for (int k = 0; k < N_TPDO; k++) last_reg[k] <= 64'h0;
    end else if (go) begin
      last_reg[sel] <= tpk[sel][63:0];
    end
  end

  // Unconfirmed send: a frame leaves once the controller takes it
  conpdo_buf #(
    .W (79)
  ) u_buf (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .flush     (~oper), // R4
    .in_valid  (go),
    .in_ready  (buf_in_ready),
    .in_data   ({tcob[sel], tpk[sel]}), // R12
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  ({tx_id, tx_dlc, tx_data})
  );

  // Receive objects; any number of nodes may consume one identifier
  logic [3:0] rhit;

  for (genvar k = 0; k < 4; k++) begin : g_rpdo
    if (k < N_RPDO) begin : g_on
      wire [10:0] rcob = rcust_reg[k] ? rcob_reg[k] : pdo_base(1'b1, 2'(k)) + {4'h0, node_id}; // R16
      assign rhit[k] = rx_valid & ~rx_rtr & (rx_id == rcob) & (rx_dlc <= `CONPDO_MAX_BYTES); // R1 R2
    end else begin : g_off
      assign rhit[k] = 1'b0;
    end
  end

  logic        rpdo_valid_reg;
  logic [1:0]  rpdo_sel_reg;
  logic [3:0]  rpdo_dlc_reg;
  logic [63:0] rpdo_data_reg;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rpdo_valid_reg <= 1'b0;
      rpdo_sel_reg   <= 2'h0;
      rpdo_dlc_reg   <= 4'h0;
      rpdo_data_reg  <= 64'h0;
    end else begin
      rpdo_valid_reg <= oper & (rhit != 4'h0); // R4
      if (oper && rhit != 4'h0) begin
        rpdo_sel_reg  <= first_set(rhit);
        rpdo_dlc_reg  <= rx_dlc;
        rpdo_data_reg <= rx_data;
      end
    end
  end

  assign rpdo_valid = rpdo_valid_reg;
  assign rpdo_sel   = rpdo_sel_reg;
  assign rpdo_dlc   = rpdo_dlc_reg;
  assign rpdo_data  = rpdo_data_reg;

endmodule : conpdo_slave

`default_nettype wire

/* testbench/conpdo_slave_properties.sv */
// Port checker of the process-data slave.
// Assumes binding onto conpdo_slave; one clock, sync active-low reset.
`timescale 1ns/1ps
`default_nettype none
module conpdo_slave_chk (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [6:0]  node_id,
  input wire logic        init_done,
  input wire logic        rx_valid,
  input wire logic [10:0] rx_id,
  input wire logic        rx_rtr,
  input wire logic [3:0]  rx_dlc,
  input wire logic [63:0] rx_data,
  input wire logic        cfg_wr,
  input wire logic        cfg_ack,
  input wire logic        cfg_err,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic [10:0] tx_id,
  input wire logic [3:0]  tx_dlc,
  input wire logic [63:0] tx_data,
  input wire logic        rpdo_valid,
  input wire logic [3:0]  rpdo_dlc,
  input wire logic [1:0]  nmt_state,
  input wire logic        operational
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire logic nmt_frame = rx_valid && !rx_rtr && rx_id == 11'h000 && rx_dlc >= 4'h2;
  wire logic for_me = rx_data[15:8] == 8'h00 || rx_data[15:8] == {1'b0, node_id};
  sequence s_start; nmt_state == 2'h1 && nmt_frame && for_me && rx_data[7:0] == 8'h01; endsequence
  sequence s_stop; nmt_state == 2'h2 && nmt_frame && for_me && rx_data[7:0] == 8'h80; endsequence
  sequence s_idle; (nmt_state != 2'h2) [*3]; endsequence
  sequence s_stalled; (tx_valid && !tx_ready && nmt_state == 2'h2) ##1 nmt_state == 2'h2; endsequence
  property p_auto_preop; nmt_state == 2'h0 && init_done |=> nmt_state == 2'h1; endproperty
  a_auto_preop: assert property (p_auto_preop) else $error("no preop after init");
  property p_start; s_start |=> nmt_state == 2'h2 && operational; endproperty
  a_start: assert property (p_start) else $error("start ignored");
  property p_stop; s_stop |=> nmt_state == 2'h1 && !operational; endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_ignore; nmt_frame && !for_me && nmt_state != 2'h0 |=> $stable(nmt_state); endproperty
  a_ignore: assert property (p_ignore) else $error("foreign command acted on");
  property p_quiet; s_idle |-> !tx_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("frame offered outside operational");
  property p_rx_oper; rpdo_valid |-> $past(nmt_state) == 2'h2; endproperty
  a_rx_oper: assert property (p_rx_oper) else $error("data passed outside operational");
  property p_cfg_ans; cfg_wr |=> cfg_ack != cfg_err; endproperty
  a_cfg_ans: assert property (p_cfg_ans) else $error("config answer missing");
  property p_cfg_oper; cfg_wr && nmt_state == 2'h2 |=> cfg_err && !cfg_ack; endproperty
  a_cfg_oper: assert property (p_cfg_oper) else $error("config taken in operational");
  property p_hold; s_stalled |-> tx_valid && $stable(tx_id) && $stable(tx_dlc) && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("stalled frame changed");
  property p_tx_len; tx_valid |-> tx_dlc <= 4'h8 && tx_dlc != 4'h0; endproperty
  a_tx_len: assert property (p_tx_len) else $error("bad transmit length");
  property p_rx_len; rpdo_valid |-> rpdo_dlc <= 4'h8; endproperty
  a_rx_len: assert property (p_rx_len) else $error("bad receive length");
endmodule : conpdo_slave_chk
bind conpdo_slave conpdo_slave_chk conpdo_slave_chk_inst (
  .ref_clk(ref_clk), .nrst(nrst), .node_id(node_id), .init_done(init_done),
  .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data),
  .cfg_wr(cfg_wr), .cfg_ack(cfg_ack), .cfg_err(cfg_err), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .rpdo_valid(rpdo_valid), .rpdo_dlc(rpdo_dlc),
  .nmt_state(nmt_state), .operational(operational)
);
`default_nettype wire

/* testbench/conpdo_net_model.sv */
// Far side of the node: master and other nodes sending frames, a consumer taking them.
// Assumes one clock; stall holds off transmit acceptance a cycle later.
`timescale 1ns/1ps
`default_nettype none
module conpdo_net_model (
  input  wire logic        ref_clk,
  input  wire logic        stall,
  output logic             rx_valid,
  output logic      [10:0] rx_id,
  output logic             rx_rtr,
  output logic      [3:0]  rx_dlc,
  output logic      [63:0] rx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [10:0] tx_id,
  input  wire logic [3:0]  tx_dlc,
  input  wire logic [63:0] tx_data
);
  logic [10:0] id_q[$];
  logic [3:0]  dlc_q[$];
  logic [63:0] dat_q[$];
  int          t_q[$];
  int          cyc = 0;
  initial begin
    rx_valid = 1'b0;
    rx_id = 11'h7ff;
    rx_rtr = 1'b1;
    rx_dlc = 4'hf;
    rx_data = 64'h0;
    tx_ready = 1'b0;
  end
  // Frames are taken with no reply frame of any kind
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    tx_ready <= !stall;
    if (tx_valid && tx_ready) begin
      id_q.push_back(tx_id);
      dlc_q.push_back(tx_dlc);
      dat_q.push_back(tx_data);
      t_q.push_back(cyc);
    end
  end
  // Produces frames on any identifier given, the node's own object identifiers included
  task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_id <= id;
    rx_rtr <= rtr;
    rx_dlc <= dlc;
    rx_data <= d;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    // Released lines carry junk, not the last frame
    rx_id <= ~id;
    rx_rtr <= ~rtr;
    rx_dlc <= ~dlc;
    rx_data <= ~d;
  endtask : send
  task automatic take(output logic [10:0] id, output logic [3:0] dlc, output logic [63:0] d, output int t);
    int n;
    n = 0;
    while (id_q.size() == 0 && n < 300) begin
      @(posedge ref_clk);
      n++;
    end
    id = 'x;
    if (id_q.size() != 0) begin
      id = id_q.pop_front();
      dlc = dlc_q.pop_front();
      d = dat_q.pop_front();
      t = t_q.pop_front();
    end
  endtask : take
  function automatic int count();
    return id_q.size();
  endfunction : count
  task automatic clear();
    id_q.delete();
    dlc_q.delete();
    dat_q.delete();
    t_q.delete();
  endtask : clear
endmodule : conpdo_net_model
`default_nettype wire

/* testbench/test_conpdo_slave.sv */
// Testbench of the process-data slave: command rows, config, triggers, stalls.
// Assumes the far-side model and the bound checker are compiled beside it.
`timescale 1ns/1ps
`default_nettype none
`include "conpdo_map.svh"
module test_conpdo_slave;
  typedef struct packed {logic [7:0] cs; logic [7:0] nd; logic [1:0] st;} conpdo_row_t;
  conpdo_row_t rows[6] = '{'{8'h01, 8'h05, 2'h1}, '{8'h02, 8'h00, 2'h1}, '{8'h01, 8'h03, 2'h2},
                           '{8'h80, 8'h00, 2'h1}, '{8'h01, 8'h00, 2'h2}, '{8'h80, 8'h03, 2'h1}};
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic init_done = 1'b0;
  logic stall = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rx = 1'b0;
  logic [1:0] cfg_sel = 2'h0;
  logic cfg_custom = 1'b0;
  logic [10:0] cfg_cob = 11'h000;
  logic [7:0] cfg_type = 8'h00;
  logic [15:0] cfg_inhibit = 16'h0000;
  logic [2:0] cfg_map_cnt = 3'h0;
  logic [7:0] cfg_map_len = 8'h00;
  logic [511:0] app_val = {32'hcafe0001, 96'h0, 32'haabbccdd, 64'h0, 64'h8877665544332211};
  logic rx_valid, rx_rtr, cfg_ack, cfg_err, tx_valid, tx_ready, rpdo_valid, operational;
  logic [10:0] rx_id, tx_id, id;
  logic [3:0] rx_dlc, tx_dlc, rpdo_dlc, dlc;
  logic [63:0] rx_data, tx_data, rpdo_data, dat;
  logic [1:0] rpdo_sel, nmt_state;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int t1, t2;
  always #20 ref_clk = ~ref_clk;
  conpdo_slave #(.N_TPDO(4), .N_RPDO(4), .UNIT_CYC(4)) conpdo_slave_inst (
    .ref_clk(ref_clk), .nrst(nrst), .node_id(7'h03), .init_done(init_done), .rx_valid(rx_valid),
    .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data), .cfg_wr(cfg_wr), .cfg_rx(cfg_rx),
    .cfg_sel(cfg_sel), .cfg_custom(cfg_custom), .cfg_cob(cfg_cob), .cfg_type(cfg_type),
    .cfg_inhibit(cfg_inhibit), .cfg_map_cnt(cfg_map_cnt), .cfg_map_len(cfg_map_len), .cfg_ack(cfg_ack),
    .cfg_err(cfg_err), .app_val(app_val), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
    .tx_dlc(tx_dlc), .tx_data(tx_data), .rpdo_valid(rpdo_valid), .rpdo_sel(rpdo_sel),
    .rpdo_dlc(rpdo_dlc), .rpdo_data(rpdo_data), .nmt_state(nmt_state), .operational(operational));
  conpdo_net_model conpdo_net_model_inst (
    .ref_clk(ref_clk), .stall(stall), .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr),
    .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id),
    .tx_dlc(tx_dlc), .tx_data(tx_data));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cfg(input logic r, input logic [1:0] s, input logic [7:0] ty, input logic [15:0] inh,
                     input logic [2:0] cnt, input logic [7:0] ln, input logic cu, input logic [10:0] cob,
                     input logic ok);
    @(posedge ref_clk);
    cfg_wr <= 1'b1;
    cfg_rx <= r;
    cfg_sel <= s;
    cfg_type <= ty;
    cfg_inhibit <= inh;
    cfg_map_cnt <= cnt;
    cfg_map_len <= ln;
    cfg_custom <= cu;
    cfg_cob <= cob;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    #1 chk({cfg_ack, cfg_err}, ok ? 2'b10 : 2'b01);
  endtask : cfg
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // Whole run needs well under 2000 cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1 chk(nmt_state, 2'h0);
    @(posedge ref_clk);
    init_done <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk(nmt_state, 2'h1);
    $display("test reset done");
    // Configuration only while pre-operational
    cfg(1'b0, 2'h0, 8'hfd, 16'h0, 3'h2, 8'h0d, 1'b0, 11'h0, 1'b1);
    cfg(1'b0, 2'h1, 8'h01, 16'h0, 3'h1, 8'h00, 1'b1, 11'h1a5, 1'b1);
    cfg(1'b0, 2'h2, 8'hff, 16'h2, 3'h1, 8'h03, 1'b0, 11'h0, 1'b1);
    cfg(1'b1, 2'h0, 8'hff, 16'h0, 3'h1, 8'h02, 1'b0, 11'h0, 1'b1);
    cfg(1'b0, 2'h3, 8'h05, 16'h0, 3'h1, 8'h00, 1'b0, 11'h0, 1'b0);
    cfg(1'b0, 2'h3, 8'hff, 16'h0, 3'h1, 8'h00, 1'b1, 11'h100, 1'b0);
    $display("test config done");
    foreach (rows[i]) begin
      conpdo_net_model_inst.send(`CONPDO_NMT_ID, 1'b0, 4'h2, {48'h0, rows[i].nd, rows[i].cs});
      @(posedge ref_clk);
      #1 chk(nmt_state, rows[i].st);
      chk(operational, rows[i].st == 2'h2);
    end
    $display("test command rows done");
    repeat (4) @(posedge ref_clk);
    conpdo_net_model_inst.clear();
    conpdo_net_model_inst.send(`CONPDO_NMT_ID, 1'b0, 4'h2, {48'h0, 8'h03, `CONPDO_CS_START});
    conpdo_net_model_inst.take(id, dlc, dat, t1);
    chk(id, 11'h383);
    chk(dlc, 4'h4);
    chk(dat[31:0], 32'hcafe0001);
    app_val[287:256] <= 32'hcafe0002;
    conpdo_net_model_inst.take(id, dlc, dat, t2);
    chk(dat[31:0], 32'hcafe0002);
    chk((t2 - t1) >= 8 && (t2 - t1) <= 14, 1'b1);
    $display("test event done");
    stall <= 1'b1;
    conpdo_net_model_inst.send(11'h183, 1'b1, 4'h0, 64'h0);
    conpdo_net_model_inst.send(`CONPDO_SYNC_ID, 1'b0, 4'h0, 64'h0);
    repeat (6) @(posedge ref_clk);
    #1 chk(tx_valid, 1'b1);
    chk(tx_id, 11'h183);
    @(posedge ref_clk);
    stall <= 1'b0;
    conpdo_net_model_inst.take(id, dlc, dat, t1);
    chk({id, dlc, dat[47:0]}, {11'h183, 4'h6, 48'h887766552211});
    conpdo_net_model_inst.take(id, dlc, dat, t1);
    chk({id, dlc, dat[7:0]}, {11'h1a5, 4'h1, 8'hdd});
    $display("test stall done");
    conpdo_net_model_inst.send(11'h203, 1'b0, 4'h3, 64'hc0ffee);
    #1 chk({rpdo_valid, rpdo_sel, rpdo_dlc, rpdo_data[23:0]}, {1'b1, 2'h0, 4'h3, 24'hc0ffee});
    cfg(1'b0, 2'h3, 8'hff, 16'h0, 3'h1, 8'h00, 1'b0, 11'h0, 1'b0);
    conpdo_net_model_inst.send(`CONPDO_NMT_ID, 1'b0, 4'h2, {48'h0, 8'h00, `CONPDO_CS_PREOP});
    conpdo_net_model_inst.send(11'h183, 1'b1, 4'h0, 64'h0);
    conpdo_net_model_inst.send(11'h203, 1'b0, 4'h3, 64'h1);
    #1 chk(rpdo_valid, 1'b0);
    repeat (10) @(posedge ref_clk);
    #1 chk(conpdo_net_model_inst.count(), 0);
    chk(tx_valid, 1'b0);
    $display("test preop silence done");
    print_verdict();
  end
endmodule : test_conpdo_slave
`default_nettype wire
